// [src/hold_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module hold_counter #(
  parameter int unsigned LIMIT = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic done
);
  localparam int unsigned WIDTH = $clog2(LIMIT + 1);
  logic [WIDTH-1:0] count;

  if (LIMIT < 1) begin : g_check
    $error("hold_counter: LIMIT must be at least 1");
  end

  // dropping run restarts the count from zero
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count <= '0;
      done <= 1'b0;
    end else if (!done) begin
      if (count == WIDTH'(LIMIT - 1)) begin
        done <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [src/pmic_mode_fsm.sv]
`timescale 1ns/1ps
`default_nettype none
module pmic_mode_fsm #(
  parameter int unsigned RESET_TIME_CYCLES = pmic_seq_pkg::RESET_CYCLES,
  parameter int unsigned DEGLITCH_TIME_CYCLES = pmic_seq_pkg::DEGLITCH_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pmic_seq_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [pmic_seq_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire pmic_seq_pkg::sense_type sense_in,
  input wire logic [pmic_seq_pkg::SUPPLY_COUNT-1:0] pgood_fault_in,
  input wire logic seq_done_in,
  input wire logic irq_pending_in,
  output logic host_reset_out_n,
  output logic int_drive_oe,
  output logic seq_enable,
  output logic comparator_enable,
  output logic [pmic_seq_pkg::SUPPLY_COUNT-1:0] supply_enable,
  output logic buck_standby,
  output logic [7:0] buck_one_standby_volt,
  output logic [7:0] buck_two_standby_volt
);
  import pmic_seq_pkg::*;

  // =====================================================================
  // input synchronisers and counters
  sense_type s;
  logic [SUPPLY_COUNT-1:0] fault_s;
  logic timer_done;
  logic hw_low_long;
  mode_type state, next_state;
  sleep_cause_type cause, next_cause;

  sync2 #(.W($bits(sense_type)), .INIT(SENSE_INIT)) u_sense_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(sense_in),
    .q(s)
  );

  sync2 #(.W(SUPPLY_COUNT), .INIT('0)) u_fault_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pgood_fault_in),
    .q(fault_s)
  );

  hold_counter #(.LIMIT(RESET_TIME_CYCLES)) u_reset_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state == ST_RESET),
    .done(timer_done)
  );

  hold_counter #(.LIMIT(DEGLITCH_TIME_CYCLES)) u_deglitch (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(!s.hw_reset_in_n),
    .done(hw_low_long)
  );

  // =====================================================================
  // registers
  logic [7:0] ctrl;
  logic [7:0] mask;
  logic [31:0] config_reg;
  logic [15:0] stby_volt;
  logic input_cycled;
  logic pg_fault;
  logic act_soft, act_sleep;
  logic load_defaults, sleep_entry;
  logic wr_do, wr_ctrl, wr_mask, wr_config, wr_volt;
  logic aw_held, w_held;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  assign pg_fault = |(fault_s & ~mask);
  assign act_soft = (state == ST_NORMAL) && ctrl[CTRL_SOFT_RESET_BIT];
  assign act_sleep = (state == ST_NORMAL) && ctrl[CTRL_SLEEP_BIT];
  assign load_defaults = (state == ST_NO_POWER) || (state == ST_HW_RESET);
  assign sleep_entry = (next_state == ST_SLEEP) && (state != ST_SLEEP);

  // =====================================================================
  // operating mode
  always_comb begin
    next_state = state;
    next_cause = cause;
    case (state)
      ST_NO_POWER: begin
        next_state = ST_ENABLE;
      end
      ST_ENABLE: begin
        if (!s.sys_low) begin
          next_state = ST_SEQUENCING;
        end
      end
      ST_SEQUENCING: begin
        if (seq_done_in) begin
          next_state = ST_RESET;
        end
      end
      ST_RESET: begin
        if (timer_done) begin
          next_state = ST_PG_CHECK;
        end
      end
      ST_PG_CHECK: begin
        if (pg_fault) begin
          next_state = ST_SLEEP;
          next_cause = CAUSE_PGOOD;
        end else begin
          next_state = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (s.thermal) begin
          next_state = ST_SLEEP;
          next_cause = CAUSE_THERMAL;
        end else if (s.sys_low) begin
          next_state = ST_SLEEP;
          next_cause = CAUSE_LOW_SYS;
        end else if (pg_fault) begin
          next_state = ST_NO_POWER;
        end else if (act_soft) begin
          next_state = ST_RESET;
        end else if (act_sleep) begin
          next_state = ST_SLEEP;
          next_cause = CAUSE_SOFT;
        end
      end
      ST_SLEEP: begin
        // thermal sleep waits for lockout below
        if (cause != CAUSE_THERMAL && s.input_present && input_cycled) begin
          next_state = ST_ENABLE;
        end
      end
      ST_HW_RESET: begin
        if (s.hw_reset_in_n) begin
          next_state = ST_RESET;
        end
      end
      default: begin
        next_state = ST_NO_POWER;
      end
    endcase
    if (s.uvlo) begin
      next_state = ST_NO_POWER;
    end else if (hw_low_long && (state == ST_NORMAL || state == ST_RESET ||
                 state == ST_PG_CHECK || state == ST_HW_RESET)) begin
      next_state = ST_HW_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_NO_POWER;
      cause <= CAUSE_NONE;
    end else begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  // an input present at sleep entry must drop once before it counts
  always_ff @(posedge aclk) begin
    if (!aresetn || sleep_entry) begin
      input_cycled <= 1'b0;
    end else if (state == ST_SLEEP && !s.input_present) begin
      input_cycled <= 1'b1;
    end
  end

  // =====================================================================
  // pin outputs, all registered; all but the standby voltages from the next mode
  logic next_run;
  assign next_run = (next_state == ST_PG_CHECK) || (next_state == ST_NORMAL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_reset_out_n <= 1'b0;
      int_drive_oe <= 1'b0;
      comparator_enable <= 1'b0;
    end else begin
      host_reset_out_n <= next_run;
      int_drive_oe <= next_run && irq_pending_in;
      comparator_enable <= next_run;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_enable <= 1'b0;
      supply_enable <= '0;
    end else if (next_state == ST_SEQUENCING || next_state == ST_RESET || next_run ||
                 next_state == ST_HW_RESET) begin
      seq_enable <= 1'b1;
      supply_enable <= config_reg[SUPPLY_COUNT-1:0];
    end else begin
      seq_enable <= 1'b0;
      supply_enable <= '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buck_standby <= 1'b0;
      buck_one_standby_volt <= STBY_VOLT_DEFAULT[7:0];
      buck_two_standby_volt <= STBY_VOLT_DEFAULT[15:8];
    end else begin
      buck_standby <= (next_state == ST_NORMAL) && (ctrl[CTRL_STANDBY_BIT] ||
                      (config_reg[CFG_STBY_PIN_BIT] && s.standby_pin));
      buck_one_standby_volt <= stby_volt[7:0];
      buck_two_standby_volt <= stby_volt[15:8];
    end
  end

  // =====================================================================
  // register storage
  assign wr_do = aw_held && w_held && !bvalid;
  assign wr_ctrl = wr_do && awaddr_q == ADDR_CTRL && wstrb_q[0];
  assign wr_mask = wr_do && awaddr_q == ADDR_MASK && wstrb_q[0];
  assign wr_config = wr_do && awaddr_q == ADDR_CONFIG;
  assign wr_volt = wr_do && awaddr_q == ADDR_STBY_VOLT;

  // soft reset touches no register but its own bit
  always_ff @(posedge aclk) begin
    if (!aresetn || load_defaults) begin
      ctrl <= CTRL_RESET;
    end else begin
      if (act_soft && next_state == ST_RESET) begin
        ctrl[CTRL_SOFT_RESET_BIT] <= 1'b0;
      end
      if (act_sleep && next_state == ST_SLEEP) begin
        ctrl[CTRL_SLEEP_BIT] <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= wdata_q[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || load_defaults) begin
      mask <= MASK_RESET;
    end else if (wr_mask) begin
      mask <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || load_defaults || sleep_entry) begin
      config_reg <= CONFIG_DEFAULT;
      stby_volt <= STBY_VOLT_DEFAULT;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (wr_config && wstrb_q[b]) begin
          config_reg[8*b +: 8] <= wdata_q[8*b +: 8];
        end
      end
      for (int b = 0; b < 2; b++) begin
        if (wr_volt && wstrb_q[b]) begin
          stby_volt[8*b +: 8] <= wdata_q[8*b +: 8];
        end
      end
    end
  end

  // =====================================================================
  // axi4-lite slave, one write and one read in flight
  logic wr_ok;
  assign wr_ok = awaddr_q == ADDR_CTRL || awaddr_q == ADDR_MASK ||
                 awaddr_q == ADDR_CONFIG || awaddr_q == ADDR_STBY_VOLT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        awaddr_q <= awaddr;
      end else if (!aw_held && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_held <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (!w_held && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  logic [31:0] rd_value;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    if (araddr == ADDR_CTRL) begin
      rd_value = {24'h0, ctrl};
    end else if (araddr == ADDR_MASK) begin
      rd_value = {24'h0, mask};
    end else if (araddr == ADDR_FAULT) begin
      rd_value = {24'h0, fault_s};
    end else if (araddr == ADDR_MODE) begin
      rd_value = {23'h0, host_reset_out_n, 1'b0, cause, 1'b0, state};
    end else if (araddr == ADDR_CONFIG) begin
      rd_value = config_reg;
    end else if (araddr == ADDR_STBY_VOLT) begin
      rd_value = {16'h0, stby_volt};
    end else begin
      rd_value = 32'h0;
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_value;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_host_low: assert property (
    state == ST_RESET |-> !host_reset_out_n && !comparator_enable)
    else $error("host reset not low in reset state");

  a_timer_exit: assert property (
    state == ST_RESET && timer_done && !s.uvlo && !hw_low_long |=> state == ST_PG_CHECK)
    else $error("reset timer expiry did not enter power-good check");

  a_int_released: assert property (
    !host_reset_out_n |-> !int_drive_oe)
    else $error("interrupt driven while host reset low");

  a_int_handover: assert property (
    $rose(host_reset_out_n) |-> int_drive_oe == $past(irq_pending_in))
    else $error("interrupt not taken over at host reset release");

  a_pg_decide: assert property (
    state == ST_PG_CHECK && !s.uvlo && !hw_low_long
      |=> state == ($past(pg_fault) ? ST_SLEEP : ST_NORMAL))
    else $error("power-good check decided wrongly");

  a_mask_blocks: assert property (
    state == ST_NORMAL && fault_s != '0 && (fault_s & ~mask) == '0 && !s.uvlo
      |=> state != ST_NO_POWER)
    else $error("masked supply caused a fault transition");

  a_mask_powerup: assert property (
    state == ST_NO_POWER ##1 state == ST_ENABLE |-> mask == MASK_RESET)
    else $error("fault mask not masked after power-up");

  a_soft_reset: assert property (
    act_soft && !s.thermal && !s.sys_low && !pg_fault && !s.uvlo && !hw_low_long
      |=> state == ST_RESET ##1 !host_reset_out_n)
    else $error("soft reset did not enter reset state");

  a_sleep_clear: assert property (
    act_sleep && next_state == ST_SLEEP && !wr_ctrl |=> !ctrl[CTRL_SLEEP_BIT])
    else $error("sleep request bit did not clear itself");

  a_sleep_off: assert property (
    state == ST_SLEEP |-> !seq_enable && supply_enable == '0 && !host_reset_out_n)
    else $error("supplies or host reset active in sleep");

  a_thermal_hold: assert property (
    state == ST_SLEEP && cause == CAUSE_THERMAL && !s.uvlo |=> state == ST_SLEEP)
    else $error("thermal sleep left without lockout");

  a_hw_release: assert property (
    state == ST_HW_RESET && s.hw_reset_in_n && !s.uvlo && !hw_low_long
      |=> state == ST_RESET)
    else $error("hardware reset release did not start reset state");

  c_normal: cover property (state == ST_PG_CHECK ##1 state == ST_NORMAL);
  c_sleep_exit: cover property (state == ST_SLEEP ##1 state == ST_ENABLE);
  c_hw_reset: cover property (state == ST_HW_RESET ##1 state == ST_RESET);
  c_standby: cover property (buck_standby && state == ST_NORMAL);
endmodule
`default_nettype wire

// [src/pmic_seq_pkg.sv]
package pmic_seq_pkg;

  // =====================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned K_RESET_NS_PER_NF = 1000000;
  localparam int unsigned RESET_CAP_NF = 10;
  localparam int unsigned RESET_CYCLES = RESET_CAP_NF * K_RESET_NS_PER_NF / CLK_PERIOD_NS;
  localparam int unsigned DEGLITCH_NS = 5000000;
  localparam int unsigned DEGLITCH_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // =====================================================================
  // register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_STBY_VOLT = 8'h14;

  localparam int unsigned CTRL_SOFT_RESET_BIT = 0;
  localparam int unsigned CTRL_LOADED_N_BIT = 1;
  localparam int unsigned CTRL_SLEEP_BIT = 6;
  localparam int unsigned CTRL_STANDBY_BIT = 7;
  localparam int unsigned CFG_STBY_PIN_BIT = 8;
  localparam int unsigned SUPPLY_COUNT = 8;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [31:0] CONFIG_DEFAULT = 32'h0000_00f0;
  localparam logic [15:0] STBY_VOLT_DEFAULT = 16'h1010;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // =====================================================================
  // types
  typedef enum logic [2:0] {
    ST_NO_POWER, ST_ENABLE, ST_SEQUENCING, ST_RESET,
    ST_PG_CHECK, ST_NORMAL, ST_SLEEP, ST_HW_RESET
  } mode_type;

  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_THERMAL, CAUSE_LOW_SYS, CAUSE_SOFT, CAUSE_PGOOD
  } sleep_cause_type;

  typedef struct packed {
    logic uvlo;
    logic input_present;
    logic battery_present;
    logic sys_low;
    logic thermal;
    logic standby_pin;
    logic hw_reset_in_n;
  } sense_type;

  localparam sense_type SENSE_INIT = '{uvlo: 1'b1, input_present: 1'b0,
    battery_present: 1'b0, sys_low: 1'b1, thermal: 1'b0, standby_pin: 1'b0,
    hw_reset_in_n: 1'b1};

endpackage

// [src/sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // meta feeds q only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// [verif/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// host side: stays off the bus while held in reset, sees the pin through a pull-up
module host_model (
  input wire logic host_reset_out_n,
  input wire logic int_drive_oe,
  output logic bus_ok,
  output logic int_line_n
);
  assign bus_ok = host_reset_out_n;
  assign int_line_n = int_drive_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// [verif/pmic_mode_fsm_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pmic_mode_fsm_tb;
  import pmic_seq_pkg::*;
  localparam int unsigned RT = 20;
  localparam int unsigned DG = 10;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, pgood, sup_en, v1, v2;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp, wr_resp;
  sense_type sense;
  logic seq_done, irq_pend, host_n, int_oe, seq_en, cmp_en, stby, bus_ok, int_n;
  int err_count, n_compared, cycles, n;

  pmic_mode_fsm #(.RESET_TIME_CYCLES(RT), .DEGLITCH_TIME_CYCLES(DG)) u_pmic_mode_fsm (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .sense_in(sense),
    .pgood_fault_in(pgood), .seq_done_in(seq_done), .irq_pending_in(irq_pend),
    .host_reset_out_n(host_n), .int_drive_oe(int_oe), .seq_enable(seq_en),
    .comparator_enable(cmp_en), .supply_enable(sup_en), .buck_standby(stby),
    .buck_one_standby_volt(v1), .buck_two_standby_volt(v2));

  host_model u_host_model (.host_reset_out_n(host_n), .int_drive_oe(int_oe),
    .bus_ok(bus_ok), .int_line_n(int_n));

  // ==========
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task final_report;
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ceiling far above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      final_report;
    end
  end

  always @(posedge aclk) begin
    if (aresetn === 1'b1 && host_n === 1'b0) chk(32'(int_n), 32'h1);
  end

  // ==========
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    while (bus_ok !== 1'b1) @(posedge aclk);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    wr_resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    while (bus_ok !== 1'b1) @(posedge aclk);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_data = rdata;
    rd_resp = rresp;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_data, exp);
  endtask

  task automatic wait_host(input logic lvl);
    while (host_n !== lvl) @(posedge aclk);
  endtask

  // input supply removed, then reconnected
  task automatic cycle_in;
    sense.input_present <= 1'b0;
    repeat (6) @(posedge aclk);
    sense.input_present <= 1'b1;
  endtask

  // ==========
  // sequence
  initial begin
    err_count = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    sense = SENSE_INIT;
    pgood = 8'h00;
    seq_done = 1'b0;
    irq_pend = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    sense.uvlo <= 1'b0;
    sense.sys_low <= 1'b0;
    sense.input_present <= 1'b1;
    sense.battery_present <= 1'b1;
    // sequencer still busy: supplies on, host held in reset
    repeat (30) @(posedge aclk);
    chk(32'(seq_en), 32'h1);
    chk(32'(host_n), 32'h0);
    seq_done <= 1'b1;
    wait_host(1'b1);
    chk(32'(int_n), 32'h0);
    irq_pend <= 1'b0;
    rdchk(ADDR_MASK, 32'h0000_00ff);
    rdchk(ADDR_CONFIG, CONFIG_DEFAULT);
    rdchk(ADDR_STBY_VOLT, 32'h0000_1010);
    chk(32'(sup_en), 32'h0000_00f0);
    rd(8'h20);
    chk(rd_data, 32'h0);
    chk(32'(rd_resp), 32'(RESP_SLVERR));
    wr(8'h20, 32'h0000_0001);
    chk(32'(wr_resp), 32'(RESP_SLVERR));
    // masked fault only shows in status, unmasked one drops power
    pgood <= 8'h08;
    repeat (4) @(posedge aclk);
    rdchk(ADDR_FAULT, 32'h0000_0008);
    rd(ADDR_MODE);
    chk(32'(rd_data[2:0]), 32'h5);
    chk(32'(rd_resp), 32'(RESP_OKAY));
    wr(ADDR_MASK, 32'h0000_00f7);
    chk(32'(wr_resp), 32'(RESP_OKAY));
    wait_host(1'b0);
    pgood <= 8'h00;
    wait_host(1'b1);
    rdchk(ADDR_MASK, 32'h0000_00ff);
    // soft reset: timed reset state, registers kept, bit self-clears
    wr(ADDR_CONFIG, 32'h0000_01a3);
    wr(ADDR_CTRL, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0003);
    wait_host(1'b0);
    n = 0;
    while (host_n === 1'b0) begin
      n++;
      chk(32'(cmp_en), 32'h0);
      @(posedge aclk);
    end
    chk(n, RT + 1);
    rdchk(ADDR_CTRL, 32'h0000_0002);
    rdchk(ADDR_CONFIG, 32'h0000_01a3);
    // standby by register bit, then by pin
    wr(ADDR_STBY_VOLT, 32'h0000_2233);
    wr(ADDR_CTRL, 32'h0000_0082);
    // standby output follows the control bit one edge after the write response
    @(posedge aclk);
    chk(32'(stby), 32'h1);
    chk({16'h0, v2, v1}, 32'h0000_2233);
    wr(ADDR_CTRL, 32'h0000_0002);
    @(posedge aclk);
    chk(32'(stby), 32'h0);
    sense.standby_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(stby), 32'h1);
    sense.standby_pin <= 1'b0;
    // sleep by register bit, exit by input cycling
    wr(ADDR_CTRL, 32'h0000_0042);
    wait_host(1'b0);
    repeat (3) @(posedge aclk);
    chk({23'h0, seq_en, sup_en}, 32'h0);
    cycle_in;
    wait_host(1'b1);
    rdchk(ADDR_STBY_VOLT, 32'h0000_1010);
    rdchk(ADDR_CONFIG, CONFIG_DEFAULT);
    rdchk(ADDR_CTRL, 32'h0000_0002);
    chk(32'(sup_en), 32'h0000_00f0);
    // unmasked fault seen at the power-good check
    wr(ADDR_MASK, 32'h0000_00fb);
    wr(ADDR_CTRL, 32'h0000_0003);
    wait_host(1'b0);
    pgood <= 8'h04;
    wait_host(1'b1);
    wait_host(1'b0);
    repeat (3) @(posedge aclk);
    chk(32'(seq_en), 32'h0);
    pgood <= 8'h00;
    cycle_in;
    wait_host(1'b1);
    rd(ADDR_MODE);
    chk(32'(rd_data[2:0]), 32'h5);
    // thermal sleep ignores input cycling, leaves only through lockout
    sense.thermal <= 1'b1;
    wait_host(1'b0);
    sense.thermal <= 1'b0;
    cycle_in;
    repeat (40) @(posedge aclk);
    chk(32'(host_n), 32'h0);
    sense.uvlo <= 1'b1;
    repeat (4) @(posedge aclk);
    sense.uvlo <= 1'b0;
    wait_host(1'b1);
    // hardware reset: short lows filtered, long low wipes registers
    wr(ADDR_CTRL, 32'h0000_0002);
    wr(ADDR_CONFIG, 32'h0000_01a3);
    repeat (2) begin
      sense.hw_reset_in_n <= 1'b0;
      repeat (DG - 2) @(posedge aclk);
      sense.hw_reset_in_n <= 1'b1;
      repeat (3) @(posedge aclk);
    end
    chk(32'(host_n), 32'h1);
    sense.hw_reset_in_n <= 1'b0;
    n = 0;
    while (host_n !== 1'b0) begin
      n++;
      @(posedge aclk);
    end
    chk(32'(n > DG), 32'h1);
    repeat (8) @(posedge aclk);
    chk(32'(host_n), 32'h0);
    sense.hw_reset_in_n <= 1'b1;
    wait_host(1'b1);
    rdchk(ADDR_CONFIG, CONFIG_DEFAULT);
    rdchk(ADDR_CTRL, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
